// ==== bench/rps_far_side.sv ====
// far side model: package pin levels and peripheral output functions facing the bank
`timescale 1ns/1ps
module rps_far_side
  import rps_pkg::*;
(
  // clock and control
  input wire logic ref_clk_in,
  input wire logic hold_in,
  // pin levels asked for by the bench
  input wire logic [RPS_NUM_PINS-1:0] pin_lvl_in,
  // levels presented to the bank
  output logic [RPS_NUM_PINS-1:0] remappable_pin_out,
  output logic [RPS_NUM_FUNCS-1:0] periph_func_out
);
  int seed = 89321;
  // pins follow the bench directly
  assign remappable_pin_out = pin_lvl_in;
  // functions change every cycle so a stale select shows, unless frozen
  initial periph_func_out = '0;
  always @(posedge ref_clk_in) begin
    if (!hold_in) begin
      periph_func_out <= {$random(seed), $random(seed)};
    end
  end
endmodule : rps_far_side

// ==== bench/rps_pin_select_bench.sv ====
// self-checking bench for the remappable pin select bank, full and 64-pin variants
`timescale 1ns/1ps
module rps_pin_select_bench;
  import rps_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  rps_bus_req_t bus = '0;
  logic [15:0] rd_a, rd_b, v;
  logic [63:0] pins = '0;
  logic [63:0] pins_w, funcs;
  logic hold = 1'b0;
  rps_periph_in_t pin_a, pin_b;
  logic [9:0] drv_a, drv_b;
  logic [31:0] exp_q[$];
  logic [5:0] sel[10];
  int err_count = 0;
  int tests_run = 0;
  int seed = 89321;
  // clock
  initial forever #2.5 ref_clk_in = ~ref_clk_in;
  rps_far_side far (.ref_clk_in(ref_clk_in), .hold_in(hold), .pin_lvl_in(pins), .remappable_pin_out(pins_w),
    .periph_func_out(funcs));
  rps_pin_select #(.PIN64_VARIANT(1'b0)) dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus_in(bus),
    .rdata_out(rd_a), .remappable_pin_in(pins_w), .periph_func_out_in(funcs), .periph_in_out(pin_a),
    .pin_drive_out(drv_a));
  rps_pin_select #(.PIN64_VARIANT(1'b1)) dut64 (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus_in(bus),
    .rdata_out(rd_b), .remappable_pin_in(pins_w), .periph_func_out_in(funcs), .periph_in_out(pin_b),
    .pin_drive_out(drv_b));
  // compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test
  // register port cycles
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    @(posedge ref_clk_in);
  endtask : rd
  // expected read of both variants: upper half 64-pin, lower half full
  function automatic logic [31:0] mk(input int i, input logic [15:0] d);
    logic [15:0] m;
    m = (i == 2) ? 16'h003f : (i < 8) ? 16'h3f3f : 16'h0000;
    mk = {((i == 5) ? 16'h003f : 16'hffff) & d & m, d & m};
  endfunction : mk
  // watcher: read data only in the answer cycle, zero otherwise
  always @(posedge ref_clk_in) begin : watch
    logic take;
    logic [31:0] e;
    take = bus.rd;
    #1;
    if (take) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hffffffff;
      check("rdata", rd_a, e[15:0]);
      check("rdata64", rd_b, e[31:16]);
    end else begin
      check("rdata_idle", rd_a, 16'h0000);
      check("rdata64_idle", rd_b, 16'h0000);
    end
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    // reset values, unmapped indices included
    for (int i = 0; i < 16; i++) begin
      rd(i[3:0], mk(i, (i < 3) ? 16'hffff : 16'h0000));
    end
    // all ones then random data, each written and read back at once
    for (int i = 0; i < 32; i++) begin
      v = (i < 16) ? 16'hffff : 16'($random(seed));
      wr(i[3:0], v);
      rd(i[3:0], mk(i % 16, v));
    end
    // random pin per peripheral input against random pin levels
    for (int k = 0; k < 6; k++) begin
      for (int f = 0; f < 5; f++) begin
        sel[f] = 6'($random(seed));
      end
      pins <= {$random(seed), $random(seed)};
      wr(4'h0, {2'b00, sel[0], 2'b00, sel[1]});
      wr(4'h1, {2'b00, sel[2], 2'b00, sel[3]});
      wr(4'h2, {10'h000, sel[4]});
      bus <= '0;
      repeat (8) @(posedge ref_clk_in);
      #1;
      for (int f = 0; f < 5; f++) begin
        check("periph_in", 16'(pin_a[4-f]), 16'(pins_w[sel[f]]));
        check("periph_in64", 16'(pin_b[4-f]), 16'(pins_w[sel[f]]));
      end
      @(posedge ref_clk_in);
    end
    // random function per output pin, functions frozen while compared
    for (int k = 0; k < 4; k++) begin
      hold <= 1'b0;
      for (int q = 0; q < 10; q++) begin
        sel[q] = 6'($random(seed));
      end
      for (int q = 0; q < 5; q++) begin
        wr(4'(3 + q), {2'b00, sel[2*q+1], 2'b00, sel[2*q]});
      end
      bus <= '0;
      hold <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      #1;
      for (int q = 0; q < 10; q++) begin
        check("pin_drive", 16'(drv_a[q]), 16'(funcs[sel[q]]));
        check("pin_drive64", 16'(drv_b[q]), (q == 5) ? 16'h0000 : 16'(funcs[sel[q]]));
      end
      @(posedge ref_clk_in);
    end
    repeat (3) @(posedge ref_clk_in);
    check("notes_left", 16'(exp_q.size()), 16'h0000);
    finish_test();
  end
endmodule : rps_pin_select_bench

// ==== hdl/rps_pin_select.sv ====
// remappable pin select bank: input routing, output routing and its register file
// What this block does
// - bits 13:8 of the first input register pick the pin for the fourth uart clear-to-send input.
// - bits 5:0 of the first input register pick the pin for the fourth uart receive input.
// - bits 13:8 of the second input register pick the pin for the third spi clock input.
// - bits 5:0 of the second input register pick the pin for the third spi data input.
// - bits 5:0 of the third input register pick the third spi slave-select pin; bits 15:6 are absent.
// - an input field value n routes the level of remappable pin n to the peripheral input.
// - reset sets every input select bit to one and clears every output select bit.
// - every unimplemented bit reads as zero.
// - an output field value n drives its pin from peripheral output function n.
// - output register k holds pin 2k in bits 5:0 and pin 2k+1 in bits 13:8, pins 0 to 9.
// - in the 64-pin variant the pin 5 output field is absent and reads zero.
`timescale 1ns/1ps
module rps_pin_select
  import rps_pkg::*;
#(
  parameter bit PIN64_VARIANT = 1'h0
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire rps_bus_req_t bus_in,
  output logic [15:0] rdata_out,
  // remappable pins and peripheral outputs
  input wire logic [RPS_NUM_PINS-1:0] remappable_pin_in,
  input wire logic [RPS_NUM_FUNCS-1:0] periph_func_out_in,
  // routed peripheral inputs and pin drive
  output rps_periph_in_t periph_in_out,
  output logic [RPS_NUM_OUT_PINS-1:0] pin_drive_out
);

  // select fields
  logic [5:0] uart_ch4_cts_pin_sel_r;
  logic [5:0] uart_ch4_rx_pin_sel_r;
  logic [5:0] spi_ch3_clk_pin_sel_r;
  logic [5:0] spi_ch3_din_pin_sel_r;
  logic [5:0] spi_ch3_select_pin_sel_r;
  logic [5:0] out_sel_r [RPS_NUM_OUT_PINS];
  logic [RPS_NUM_PINS-1:0] pin_s1_r;
  logic [RPS_NUM_PINS-1:0] pin_s2_r;
  logic [RPS_NUM_PINS-1:0] pin_s3_r;
  logic [RPS_NUM_PINS-1:0] pin_lvl_r;
  logic [15:0] rdata_nxt;
  logic [3:0] out_k;

  // true when pin p has a writable output field
  function automatic logic pin_present(input int p);
    pin_present = !(PIN64_VARIANT && (p == RPS_ABSENT_PIN));
  endfunction : pin_present

  // packs two fields into a register image, absent bits zero
  function automatic logic [15:0] pack_pair(input logic [5:0] hi, input logic [5:0] lo);
    pack_pair = {2'h0, hi, 2'h0, lo};
  endfunction : pack_pair

  // true when the index names one of the output-select registers
  function automatic logic is_out_route(input logic [3:0] idx);
    is_out_route = (idx >= RPS_IDX_OUT_ROUTE_0) && (idx <= RPS_IDX_OUT_ROUTE_4);
  endfunction : is_out_route

  // output register number; wraps below the first output index, so only trusted with is_out_route
  assign out_k = 4'(bus_in.addr - RPS_IDX_OUT_ROUTE_0);

  // input-select register writes
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      uart_ch4_cts_pin_sel_r <= RPS_IN_SEL_RST;
      uart_ch4_rx_pin_sel_r <= RPS_IN_SEL_RST;
      spi_ch3_clk_pin_sel_r <= RPS_IN_SEL_RST;
      spi_ch3_din_pin_sel_r <= RPS_IN_SEL_RST;
      spi_ch3_select_pin_sel_r <= RPS_IN_SEL_RST;
    end else if (bus_in.wr) begin
      unique case (bus_in.addr)
        RPS_IDX_UART4_ROUTE: begin
          uart_ch4_cts_pin_sel_r <= bus_in.wdata[RPS_HI_FIELD_POS +: RPS_SEL_W];
          uart_ch4_rx_pin_sel_r <= bus_in.wdata[RPS_LO_FIELD_POS +: RPS_SEL_W];
        end
        RPS_IDX_SPI3_CD_ROUTE: begin
          spi_ch3_clk_pin_sel_r <= bus_in.wdata[RPS_HI_FIELD_POS +: RPS_SEL_W];
          spi_ch3_din_pin_sel_r <= bus_in.wdata[RPS_LO_FIELD_POS +: RPS_SEL_W];
        end
        RPS_IDX_SPI3_SS_ROUTE: begin
          spi_ch3_select_pin_sel_r <= bus_in.wdata[RPS_LO_FIELD_POS +: RPS_SEL_W];
        end
        default: begin
        end
      endcase
    end
  end

  // output-select register writes, two pins per register
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < RPS_NUM_OUT_PINS; i++) begin
        out_sel_r[i] <= RPS_OUT_SEL_RST;
      end
    end else if (bus_in.wr && is_out_route(bus_in.addr)) begin
      for (int k = 0; k < RPS_NUM_OUT_PINS / 2; k++) begin
        if (out_k == 4'(k)) begin
          out_sel_r[2*k] <= bus_in.wdata[RPS_LO_FIELD_POS +: RPS_SEL_W];
          if (pin_present(2*k+1)) begin
            out_sel_r[2*k+1] <= bus_in.wdata[RPS_HI_FIELD_POS +: RPS_SEL_W];
          end
        end
      end
    end
  end

  // read data mux, zero for absent bits and unmapped indices
  always_comb begin
    rdata_nxt = 16'h0000;
    unique case (bus_in.addr)
      RPS_IDX_UART4_ROUTE: rdata_nxt = pack_pair(uart_ch4_cts_pin_sel_r, uart_ch4_rx_pin_sel_r);
      RPS_IDX_SPI3_CD_ROUTE: rdata_nxt = pack_pair(spi_ch3_clk_pin_sel_r, spi_ch3_din_pin_sel_r);
      RPS_IDX_SPI3_SS_ROUTE: rdata_nxt = pack_pair(6'h00, spi_ch3_select_pin_sel_r);
      default: begin
        for (int k = 0; k < RPS_NUM_OUT_PINS / 2; k++) begin
          if (is_out_route(bus_in.addr) && out_k == 4'(k)) begin
            rdata_nxt = pack_pair(pin_present(2*k+1) ? out_sel_r[2*k+1] : 6'h00, out_sel_r[2*k]);
          end
        end
      end
    endcase
  end

  // read data register, valid the cycle after the strobe
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_out <= 16'h0000;
    end else if (bus_in.rd) begin
      rdata_out <= rdata_nxt;
    end else begin
      // zero outside the answer cycle, so a late sampler never takes a stale read
      rdata_out <= 16'h0000;
    end
  end

  // three-stage pin synchroniser; level accepted when stages two and three agree
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_lvl_r <= '0;
    end else begin
      pin_s1_r <= remappable_pin_in;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      // a one-cycle glitch never makes stages two and three agree, so it never reaches a peripheral
      for (int p = 0; p < RPS_NUM_PINS; p++) begin
        if (pin_s2_r[p] == pin_s3_r[p]) begin
          pin_lvl_r[p] <= pin_s3_r[p];
        end
      end
    end
  end

  // route the selected pin level to each peripheral input
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      periph_in_out <= '0;
    end else begin
      periph_in_out.uart_ch4_cts_input <= pin_lvl_r[uart_ch4_cts_pin_sel_r];
      periph_in_out.uart_ch4_rx_input <= pin_lvl_r[uart_ch4_rx_pin_sel_r];
      periph_in_out.spi_ch3_clk_input <= pin_lvl_r[spi_ch3_clk_pin_sel_r];
      periph_in_out.spi_ch3_data_input <= pin_lvl_r[spi_ch3_din_pin_sel_r];
      periph_in_out.spi_ch3_select_input <= pin_lvl_r[spi_ch3_select_pin_sel_r];
    end
  end

  // drive each of the 10 output pins from its selected function output; pin 5 of the 64-pin variant is held low
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pin_drive_out <= '0;
    end else begin
      for (int p = 0; p < RPS_NUM_OUT_PINS; p++) begin
        pin_drive_out[p] <= pin_present(p) ? periph_func_out_in[out_sel_r[p]] : 1'h0;
      end
    end
  end

  // assertions
  property p_rst_in_sel;
    @(posedge ref_clk_in) !rst_n_in |=> uart_ch4_rx_pin_sel_r == 6'h3f && spi_ch3_select_pin_sel_r == 6'h3f;
  endproperty
  a_rst_in_sel: assert property (p_rst_in_sel) else $error("input select not all ones after reset");

  property p_rst_out_sel;
    @(posedge ref_clk_in) !rst_n_in |=> out_sel_r[0] == 6'h00 && out_sel_r[9] == 6'h00;
  endproperty
  a_rst_out_sel: assert property (p_rst_out_sel) else $error("output select not zero after reset");

  sequence s_wr_uart4;
    bus_in.wr && bus_in.addr == RPS_IDX_UART4_ROUTE;
  endsequence
  property p_cts_write;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_wr_uart4 |=> uart_ch4_cts_pin_sel_r == $past(bus_in.wdata[13:8]);
  endproperty
  a_cts_write: assert property (p_cts_write) else $error("cts field not written from bits 13:8");

  property p_rx_write;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_wr_uart4 |=> uart_ch4_rx_pin_sel_r == $past(bus_in.wdata[5:0]);
  endproperty
  a_rx_write: assert property (p_rx_write) else $error("rx field not written from bits 5:0");

  property p_spi_clk_write;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus_in.wr && bus_in.addr == RPS_IDX_SPI3_CD_ROUTE |=> spi_ch3_clk_pin_sel_r == $past(bus_in.wdata[13:8]);
  endproperty
  a_spi_clk_write: assert property (p_spi_clk_write) else $error("spi clock field wrong");

  property p_spi_din_write;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus_in.wr && bus_in.addr == RPS_IDX_SPI3_CD_ROUTE |=> spi_ch3_din_pin_sel_r == $past(bus_in.wdata[5:0]);
  endproperty
  a_spi_din_write: assert property (p_spi_din_write) else $error("spi data field wrong");

  property p_ss_read;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus_in.rd && bus_in.addr == RPS_IDX_SPI3_SS_ROUTE |=> rdata_out == {10'h000, $past(spi_ch3_select_pin_sel_r)};
  endproperty
  a_ss_read: assert property (p_ss_read) else $error("slave select register read wrong");

  property p_rx_route;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ##1 periph_in_out.uart_ch4_rx_input == $past(pin_lvl_r[uart_ch4_rx_pin_sel_r]);
  endproperty
  a_rx_route: assert property (p_rx_route) else $error("rx input not from selected pin");

  property p_unimpl_zero;
    @(posedge ref_clk_in) disable iff (!rst_n_in) rdata_out[15:14] == 2'h0 && rdata_out[7:6] == 2'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read nonzero");

  property p_out_route;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ##1 pin_drive_out[0] == $past(periph_func_out_in[out_sel_r[0]]);
  endproperty
  a_out_route: assert property (p_out_route) else $error("pin 0 not driven from selected function");

  property p_out_pair;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus_in.wr && bus_in.addr == RPS_IDX_OUT_ROUTE_4 |=> out_sel_r[8] == $past(bus_in.wdata[5:0])
        && out_sel_r[9] == $past(bus_in.wdata[13:8]);
  endproperty
  a_out_pair: assert property (p_out_pair) else $error("output register 4 field split wrong");

  property p_pin5_absent;
    @(posedge ref_clk_in) disable iff (!rst_n_in) PIN64_VARIANT |-> out_sel_r[5] == 6'h00 && !pin_drive_out[5];
  endproperty
  a_pin5_absent: assert property (p_pin5_absent) else $error("pin 5 field present in small variant");

  property p_readback;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_wr_uart4 ##1 (bus_in.rd && bus_in.addr == RPS_IDX_UART4_ROUTE && !bus_in.wr)
        |=> rdata_out == ($past(bus_in.wdata, 2) & 16'h3f3f);
  endproperty
  a_readback: assert property (p_readback) else $error("read back differs from written value");

  // reset also clears the read data and every routed output
  property p_rst_outputs;
    @(posedge ref_clk_in) !rst_n_in |=> rdata_out == 16'h0000 && periph_in_out == '0 && pin_drive_out == '0;
  endproperty
  a_rst_outputs: assert property (p_rst_outputs) else $error("outputs not cleared by reset");

  sequence s_wr_spi3_ss;
    bus_in.wr && bus_in.addr == RPS_IDX_SPI3_SS_ROUTE;
  endsequence
  property p_ss_write;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_wr_spi3_ss |=> spi_ch3_select_pin_sel_r == $past(bus_in.wdata[5:0]);
  endproperty
  a_ss_write: assert property (p_ss_write) else $error("slave select field not written from bits 5:0");

  // each routed input follows the level of its selected pin one cycle on
  property p_cts_route;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ##1 periph_in_out.uart_ch4_cts_input == $past(pin_lvl_r[uart_ch4_cts_pin_sel_r]);
  endproperty
  a_cts_route: assert property (p_cts_route) else $error("cts input not from selected pin");

  property p_clk_route;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ##1 periph_in_out.spi_ch3_clk_input == $past(pin_lvl_r[spi_ch3_clk_pin_sel_r]);
  endproperty
  a_clk_route: assert property (p_clk_route) else $error("spi clock input not from selected pin");

  property p_din_route;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ##1 periph_in_out.spi_ch3_data_input == $past(pin_lvl_r[spi_ch3_din_pin_sel_r]);
  endproperty
  a_din_route: assert property (p_din_route) else $error("spi data input not from selected pin");

  property p_ss_route;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ##1 periph_in_out.spi_ch3_select_input == $past(pin_lvl_r[spi_ch3_select_pin_sel_r]);
  endproperty
  a_ss_route: assert property (p_ss_route) else $error("spi select input not from selected pin");

  property p_rdata_idle;
    @(posedge ref_clk_in) disable iff (!rst_n_in) !bus_in.rd |=> rdata_out == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data present outside its answer cycle");

  // a write to an index beyond the map leaves every field alone
  property p_unmapped_write;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus_in.wr && bus_in.addr > RPS_IDX_OUT_ROUTE_4 |=> $stable(uart_ch4_cts_pin_sel_r)
        && $stable(spi_ch3_select_pin_sel_r) && $stable(out_sel_r[0]) && $stable(out_sel_r[9]);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("write beyond the map changed a field");

  property p_out_first_pair;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus_in.wr && bus_in.addr == RPS_IDX_OUT_ROUTE_0 |=> out_sel_r[0] == $past(bus_in.wdata[5:0])
        && out_sel_r[1] == $past(bus_in.wdata[13:8]);
  endproperty
  a_out_first_pair: assert property (p_out_first_pair) else $error("output register 0 field split wrong");

  sequence s_wr_pin5_route;
    bus_in.wr && is_out_route(bus_in.addr) && out_k == 4'h2;
  endsequence
  property p_pin5_write;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      s_wr_pin5_route |=> out_sel_r[5] == (PIN64_VARIANT ? 6'h00 : $past(bus_in.wdata[13:8]));
  endproperty
  a_pin5_write: assert property (p_pin5_write) else $error("pin 5 field write wrong for this variant");

  property p_out_read;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      bus_in.rd && bus_in.addr == RPS_IDX_OUT_ROUTE_4 |=> rdata_out == {2'h0, $past(out_sel_r[9]), 2'h0,
        $past(out_sel_r[8])};
  endproperty
  a_out_read: assert property (p_out_read) else $error("output register 4 read wrong");

  property p_out_route_last;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ##1 pin_drive_out[9] == $past(periph_func_out_in[out_sel_r[9]]);
  endproperty
  a_out_route_last: assert property (p_out_route_last) else $error("pin 9 not driven from selected function");

  // the accepted level of a pin moves only after stages two and three agreed on it
  property p_sync_agree;
    @(posedge ref_clk_in) disable iff (!rst_n_in)
      ##1 ((pin_lvl_r ^ $past(pin_lvl_r)) & ($past(pin_s2_r) ^ $past(pin_s3_r))) == '0;
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("pin level taken before stages agreed");

endmodule : rps_pin_select

// ==== hdl/rps_pkg.sv ====
// package: register map, field layout and reset values of the remappable pin select bank
package rps_pkg;
  // register indices (no printed offsets; chosen map, one 16-bit register per index)
  localparam logic [3:0] RPS_IDX_UART4_ROUTE = 4'h0;
  localparam logic [3:0] RPS_IDX_SPI3_CD_ROUTE = 4'h1;
  localparam logic [3:0] RPS_IDX_SPI3_SS_ROUTE = 4'h2;
  localparam logic [3:0] RPS_IDX_OUT_ROUTE_0 = 4'h3;
  localparam logic [3:0] RPS_IDX_OUT_ROUTE_4 = 4'h7;
  // field positions
  localparam int RPS_LO_FIELD_POS = 0;
  localparam int RPS_HI_FIELD_POS = 8;
  localparam int RPS_SEL_W = 6;
  // reset values of select fields
  localparam logic [5:0] RPS_IN_SEL_RST = 6'h3f;
  localparam logic [5:0] RPS_OUT_SEL_RST = 6'h00;
  // pin counts
  localparam int RPS_NUM_PINS = 64;
  localparam int RPS_NUM_OUT_PINS = 10;
  localparam int RPS_NUM_FUNCS = 64;
  localparam int RPS_ABSENT_PIN = 5;
  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } rps_bus_req_t;
  // peripheral inputs routed from pins
  typedef struct packed {
    logic uart_ch4_cts_input;
    logic uart_ch4_rx_input;
    logic spi_ch3_clk_input;
    logic spi_ch3_data_input;
    logic spi_ch3_select_input;
  } rps_periph_in_t;
endpackage : rps_pkg
